// ==== hdl/lcfs_defines.vh ====
// Register offsets, fields and timing constants for the fade sequencer
`ifndef LCFS_DEFINES_VH
`define LCFS_DEFINES_VH
`define LCFS_ADDR_FADE      7'h11
`define LCFS_ADDR_RAMP      7'h12
`define LCFS_ADDR_CFG       7'h01
`define LCFS_FADE_RST       8'h00
`define LCFS_RAMP_RST       8'h00
`define LCFS_FADE_LSB       0
`define LCFS_HOLD_LSB       3
`define LCFS_CFG_RUN        0
`define LCFS_CFG_RAMP_EN    1
`define LCFS_CFG_CS_RUN     2
`define LCFS_CFG_ST_HOLD    3
`define LCFS_CFG_ST_FADE    4
`define LCFS_CFG_ST_RAMP    5
`define LCFS_TICK_HZ        32768
`define LCFS_BASE_DIV       16
`define LCFS_BASE_TICKS     18'h00800
`define LCFS_DAC_STEPS      8
`define LCFS_STEP_TICKS     18'h00100
`endif

// ==== hdl/lcfs_sequencer.v ====
// Hold-off, fade-off and ramp-up sequencer driving a 3-bit reference DAC
//
// Operation
// - Fade register holds hold-off and fade-off fields; zero skips that delay.
// - Fade code 0 shuts down at once; 1..7 fade over 1/16s to 4s.
// - Hold code 0 no delay; 1..7 hold 1/16s to 4s before fading.
// - Ramp code 0 gives instant full current; 1..7 ramp 1/16s to 4s.
// - Config register reports hold-off, fade-off and ramp-up status bits.
// - A config bit enables or disables ramp-up on restart.
// - One config write starts shutdown and selects restart options.
// - All intervals are timed from the selected PWM tick.
// - Internal oscillator is kept running throughout any sequence.
// - Ramping drives a 3-bit DAC scaling the master reference.
// - Master scaling changes all outputs by the same ratio.
// - Global maximum current caps the DAC level during ramps.
// - Outputs stay at full programmed current during hold-off.
// - Ramps proceed autonomously with no further host action.
`timescale 1ns/1ns
`include "lcfs_defines.vh"
module lcfs_sequencer (
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Register access
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [6:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Tick sources and selection
  input  wire       internal_tick,
  input  wire       external_tick_input,
  input  wire       use_external_tick,
  output reg        osc_keep_on,
  // Restart on chip select
  input  wire       cs_restart,
  // Global current and outputs
  input  wire [2:0] global_current,
  output reg  [2:0] dac_level,
  output reg        shutdown
);
  localparam [4:0] ST_RUN  = 5'h01;
  localparam [4:0] ST_HOLD = 5'h02;
  localparam [4:0] ST_FADE = 5'h04;
  localparam [4:0] ST_SHDN = 5'h08;
  localparam [4:0] ST_RAMP = 5'h10;
  // A 4 s hold spans 2^17 ticks, so counts are 18 bits wide
  localparam [17:0] BASE_TICKS = `LCFS_BASE_TICKS;
  localparam [17:0] STEP_BASE  = `LCFS_STEP_TICKS;

  reg [7:0]  fade_q;
  reg [7:0]  ramp_q;
  reg        ramp_en_q;
  reg        cs_run_q;
  reg [4:0]  state_q;
  reg [17:0] tick_cnt_q;
  reg [2:0]  level_q;
  reg [2:0]  sync_q;
  reg        tick_last_q;
  reg [2:0]  csr_q;
  reg        cs_last_q;

  // Interval in tick periods for a nonzero code, base 2048 per 1/16 s
  function [17:0] lcfs_len;
    input [2:0] code;
    begin
      lcfs_len = BASE_TICKS << (code - 3'h1);
    end
  endfunction

  // Ticks per DAC step: interval spread evenly across eight levels
  function [17:0] lcfs_step;
    input [2:0] code;
    begin
      lcfs_step = STEP_BASE << (code - 3'h1);
    end
  endfunction

  wire [2:0] hold_code = fade_q[`LCFS_HOLD_LSB+2:`LCFS_HOLD_LSB];
  wire [2:0] fade_code = fade_q[`LCFS_FADE_LSB+2:`LCFS_FADE_LSB];
  wire [2:0] ramp_code = ramp_q[2:0];
  // Tick input from either oscillator; stages 2 and 3 must agree
  wire       tick_src  = use_external_tick ? external_tick_input : internal_tick;
  wire       tick_now  = (sync_q[1] == sync_q[2]) ? sync_q[2] : tick_last_q;
  wire       tick_rise = tick_now & ~tick_last_q;
  wire       cs_now    = (csr_q[1] == csr_q[2]) ? csr_q[2] : cs_last_q;
  wire       cs_rise   = cs_now & ~cs_last_q;
  wire       cfg_wr    = reg_wr && (reg_addr == `LCFS_ADDR_CFG);
  // Restart word itself may choose ramp-up, so use its bit when writing
  wire       ramp_use  = cfg_wr ? reg_wdata[`LCFS_CFG_RAMP_EN] : ramp_en_q;
  // Slice done: hold length reached, or step ticks reached within current level
  wire       hold_done = tick_rise && (tick_cnt_q >= lcfs_len(hold_code) - 18'h1);
  wire       fstep     = tick_rise && (tick_cnt_q >= lcfs_step(fade_code) - 18'h1);
  wire       rstep     = tick_rise && (tick_cnt_q >= lcfs_step(ramp_code) - 18'h1);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q      <= 3'h0;
      tick_last_q <= 1'b0;
      csr_q       <= 3'h0;
      cs_last_q   <= 1'b0;
    end else begin
      sync_q      <= {sync_q[1:0], tick_src};
      tick_last_q <= tick_now;
      csr_q       <= {csr_q[1:0], cs_restart};
      cs_last_q   <= cs_now;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fade_q    <= `LCFS_FADE_RST;
      ramp_q    <= `LCFS_RAMP_RST;
      ramp_en_q <= 1'b0;
      cs_run_q  <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `LCFS_ADDR_FADE)
        fade_q <= {2'h0, reg_wdata[5:0]};
      if (reg_addr == `LCFS_ADDR_RAMP)
        ramp_q <= {5'h0, reg_wdata[2:0]};
      if (cfg_wr) begin
        ramp_en_q <= reg_wdata[`LCFS_CFG_RAMP_EN];
        cs_run_q  <= reg_wdata[`LCFS_CFG_CS_RUN];
      end
    end
  end

  // Sequence engine; no host action needed once started
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= ST_RUN;
      tick_cnt_q <= 18'h0;
      level_q    <= 3'h7;
    end else begin
      case (state_q)
        ST_RUN: begin
          tick_cnt_q <= 18'h0;
          level_q    <= 3'h7;
          if (cfg_wr && !reg_wdata[`LCFS_CFG_RUN]) begin
            if (hold_code != 3'h0)
              state_q <= ST_HOLD;
            else if (fade_code != 3'h0)
              state_q <= ST_FADE;
            else
              state_q <= ST_SHDN;
          end
        end
        ST_HOLD: begin
          // Full level kept during the delay
          level_q <= 3'h7;
          if (hold_done) begin
            tick_cnt_q <= 18'h0;
            state_q    <= (fade_code != 3'h0) ? ST_FADE : ST_SHDN;
          end else if (tick_rise)
            tick_cnt_q <= tick_cnt_q + 18'h1;
        end
        ST_FADE: begin
          // Eighth step leaves level zero for shutdown
          if (fstep) begin
            tick_cnt_q <= 18'h0;
            if (level_q == 3'h0)
              state_q <= ST_SHDN;
            else
              level_q <= level_q - 3'h1;
          end else if (tick_rise)
            tick_cnt_q <= tick_cnt_q + 18'h1;
        end
        ST_SHDN: begin
          // Level parks at zero so a ramp climbs all eight steps
          tick_cnt_q <= 18'h0;
          level_q    <= 3'h0;
          if ((cfg_wr && reg_wdata[`LCFS_CFG_RUN]) || (cs_run_q && cs_rise)) begin
            if (ramp_use && ramp_code != 3'h0)
              state_q <= ST_RAMP;
            else begin
              state_q <= ST_RUN;
              level_q <= 3'h7;
            end
          end
        end
        ST_RAMP: begin
          if (rstep) begin
            tick_cnt_q <= 18'h0;
            if (level_q == 3'h7)
              state_q <= ST_RUN;
            else
              level_q <= level_q + 3'h1;
          end else if (tick_rise)
            tick_cnt_q <= tick_cnt_q + 18'h1;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_level   <= 3'h7;
      shutdown    <= 1'b0;
      osc_keep_on <= 1'b0;
      reg_rdata   <= 8'h0;
    end else begin
      // DAC level never exceeds the global cap, so a fade stays at the cap until the level falls below it
      dac_level   <= (level_q < global_current) ? level_q : global_current;
      shutdown    <= (state_q == ST_SHDN);
      osc_keep_on <= (state_q == ST_HOLD) || (state_q == ST_FADE) || (state_q == ST_RAMP);
      if (reg_rd) begin
        case (reg_addr)
          `LCFS_ADDR_FADE: reg_rdata <= fade_q;
          `LCFS_ADDR_RAMP: reg_rdata <= ramp_q;
          `LCFS_ADDR_CFG:  reg_rdata <= {2'h0, state_q == ST_RAMP, state_q == ST_FADE,
                                         state_q == ST_HOLD, cs_run_q, ramp_en_q,
                                         state_q != ST_SHDN};
          default:         reg_rdata <= 8'h0;
        endcase
      end
    end
  end
endmodule

// ==== tb/lcfs_chk.sv ====
// Port checker for the fade sequencer
`timescale 1ns/1ns
`include "lcfs_defines.vh"
module lcfs_chk (
  // Clock and reset
  input wire       clk,
  input wire       reset_n,
  // Register access
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Sequencer outputs and global current input
  input wire       osc_keep_on,
  input wire [2:0] global_current,
  input wire [2:0] dac_level,
  input wire       shutdown
);
  reg [5:0] fade_q;
  reg [2:0] ramp_q;
  // Shadow copies, so reads can be judged without trusting the design
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fade_q <= 6'h00;
      ramp_q <= 3'h0;
    end else if (reg_wr && reg_addr == `LCFS_ADDR_FADE) begin
      fade_q <= reg_wdata[5:0];
    end else if (reg_wr && reg_addr == `LCFS_ADDR_RAMP) begin
      ramp_q <= reg_wdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence down_req_s;
    reg_wr && reg_addr == `LCFS_ADDR_CFG && !reg_wdata[`LCFS_CFG_RUN];
  endsequence
  sequence level_move_s;
    $changed(dac_level) && $stable(global_current) && osc_keep_on && $past(osc_keep_on, 2) && !shutdown;
  endsequence
  dac_cap_a: assert property (dac_level <= $past(global_current)) else $error("dac above cap");
  shut_fast_a: assert property (down_req_s and fade_q == 6'h00 |-> ##[1:4] shutdown) else $error("no shutdown");
  osc_run_a: assert property (down_req_s and fade_q != 6'h00 |-> ##[1:4] osc_keep_on) else $error("osc off");
  osc_idle_a: assert property (shutdown && $past(shutdown) |-> !osc_keep_on) else $error("osc in shutdown");
  hold_full_a: assert property ($rose(osc_keep_on) && !$past(shutdown) |-> dac_level == global_current)
    else $error("not full at start");
  dac_step_a: assert property (level_move_s |-> (dac_level - $past(dac_level) == 3'h1)
    || ($past(dac_level) - dac_level == 3'h1)) else $error("dac jumped");
  rd_fade_a: assert property (reg_rd && reg_addr == `LCFS_ADDR_FADE |=> reg_rdata == {2'h0, fade_q})
    else $error("fade read");
  rd_ramp_a: assert property (reg_rd && reg_addr == `LCFS_ADDR_RAMP |=> reg_rdata == {5'h00, ramp_q})
    else $error("ramp read");
endmodule
bind lcfs_sequencer lcfs_chk i_lcfs_chk (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .osc_keep_on, .global_current, .dac_level, .shutdown);

// ==== tb/lcfs_led_load.sv ====
// LED load model on the sink outputs
`timescale 1ns/1ns
module lcfs_led_load (
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Drive from the sequencer
  input  wire [2:0] dac_level,
  input  wire       shutdown,
  // Load current in DAC steps
  output reg  [2:0] load_level
);
  // One reference feeds all ten sinks, so one level stands for all
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) load_level <= 3'h0;
    else load_level <= shutdown ? 3'h0 : dac_level;
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the fade sequencer
`timescale 1ns/1ns
`include "lcfs_defines.vh"
module tb_top;
  reg        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cs_restart = 1'b0;
  reg        internal_tick = 1'b0, external_tick_input = 1'b0, use_external_tick = 1'b0;
  reg  [6:0] reg_addr = 7'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg  [2:0] global_current = 3'h7;
  wire [7:0] reg_rdata;
  wire [2:0] dac_level, load_level;
  wire       osc_keep_on, shutdown;
  integer    bad_count = 0, cmp_count = 0, cyc = 0, n;
  lcfs_sequencer i_lcfs_sequencer (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .internal_tick, .external_tick_input, .use_external_tick, .osc_keep_on, .cs_restart, .global_current,
    .dac_level, .shutdown);
  lcfs_led_load i_lcfs_led_load (.clk, .reset_n, .dac_level, .shutdown, .load_level);
  always #10 clk = ~clk;
  // Only the selected source runs, so a wrong select stalls the sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    internal_tick <= !use_external_tick && (cyc % 6) < 3;
    external_tick_input <= use_external_tick && (cyc % 6) < 3;
    if (cyc == 90000) begin
      bad_count = bad_count + 1;
      conclude;
    end
  end
  task chk(input [7:0] exp, input [7:0] got, input [8*10:1] nm);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input [6:0] a, input [7:0] exp, input [8*10:1] nm);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    @(posedge clk) #1 chk(exp, reg_rdata, nm);
  endtask
  task t_regs;
    rd(`LCFS_ADDR_FADE, 8'h00, "fade rst");
    rd(`LCFS_ADDR_CFG, 8'h01, "cfg rst");
    wr(`LCFS_ADDR_FADE, 8'hff);
    rd(`LCFS_ADDR_FADE, 8'h3f, "fade rw");
    wr(`LCFS_ADDR_RAMP, 8'hff);
    rd(`LCFS_ADDR_RAMP, 8'h07, "ramp rw");
    rd(7'h20, 8'h00, "unmapped");
    $display("test regs done");
  endtask
  task t_instant;
    wr(`LCFS_ADDR_FADE, 8'h00);
    wr(`LCFS_ADDR_CFG, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk(8'h01, {7'h00, shutdown}, "shut now");
    wr(`LCFS_ADDR_CFG, 8'h01);
    repeat (4) @(posedge clk);
    #1 chk(8'h07, {4'h0, shutdown, load_level}, "no ramp");
    $display("test instant done");
  endtask
  task t_fade;
    @(posedge clk) use_external_tick <= 1'b1;
    wr(`LCFS_ADDR_FADE, 8'h09);
    wr(`LCFS_ADDR_CFG, 8'h00);
    rd(`LCFS_ADDR_CFG, 8'h09, "hold stat");
    chk(8'h07, {5'h00, dac_level}, "hold full");
    for (n = 0; dac_level === 3'h7 && n < 30000; n = n + 1) @(posedge clk) #1;
    // Hold of 2048 ticks plus first fade step of 256, six clocks per tick
    chk(8'h01, {7'h00, n > 13700 && n < 13900}, "hold time");
    rd(`LCFS_ADDR_CFG, 8'h11, "fade stat");
    for (n = 0; shutdown !== 1'b1 && n < 30000; n = n + 1) @(posedge clk) #1;
    // Seven more fade steps of 256 ticks each
    chk(8'h01, {7'h00, n > 10700 && n < 10800}, "fade time");
    rd(`LCFS_ADDR_CFG, 8'h00, "shut stat");
    @(posedge clk) use_external_tick <= 1'b0;
    $display("test fade done");
  endtask
  task t_ramp;
    global_current <= 3'h5;
    wr(`LCFS_ADDR_FADE, 8'h00);
    wr(`LCFS_ADDR_RAMP, 8'h01);
    wr(`LCFS_ADDR_CFG, 8'h06);
    repeat (4) @(posedge clk);
    cs_restart <= 1'b1;
    // Pin passes three flops before the restart edge is seen
    repeat (4) @(posedge clk);
    rd(`LCFS_ADDR_CFG, 8'h27, "ramp stat");
    for (n = 0; osc_keep_on !== 1'b0 && n < 30000; n = n + 1) @(posedge clk) #1;
    chk(8'h01, {7'h00, n > 12200 && n < 12400}, "ramp time");
    repeat (2) @(posedge clk);
    chk(8'h05, {5'h00, load_level}, "ramp cap");
    rd(`LCFS_ADDR_CFG, 8'h07, "run stat");
    @(posedge clk) cs_restart <= 1'b0;
    $display("test ramp done");
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_instant;
    t_fade;
    t_ramp;
    conclude;
  end
endmodule
